// ### tpm_pkg.sv
package tpm_pkg;

    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    localparam logic [6:0] TPM_DEV_ADDR   = 7'h2a;
    localparam logic [7:0] TPM_HDR0       = 8'h67;
    localparam logic [7:0] TPM_HDR1       = 8'h00;
    localparam logic [7:0] TPM_LEN_LO     = 8'h42;
    localparam logic [7:0] TPM_LEN_HI     = 8'h00;
    localparam logic [7:0] TPM_RPT_DIAG   = 8'h03;
    localparam logic [6:0] TPM_CMD_BYTES  = 7'h0a;
    localparam logic [6:0] TPM_BYTE_MAX   = 7'h7f;
    localparam logic [3:0] TPM_ACK_BIT    = 4'h8;
    localparam logic [3:0] TPM_LAST_BIT   = 4'h7;

    // ------------------------------------------------------------
    // Command and reply codes
    // ------------------------------------------------------------
    localparam logic [7:0] TPM_SUB_QUERY  = 8'h01;
    localparam logic [7:0] TPM_QUERY_CHAR = 8'h45;
    localparam logic [7:0] TPM_SUB_SLEEP  = 8'h03;
    localparam logic [7:0] TPM_SUB_IDLE   = 8'h04;
    localparam logic [7:0] TPM_PWR_B6     = 8'h36;
    localparam logic [7:0] TPM_PWR_B7     = 8'h3f;
    localparam logic [7:0] TPM_ARG_IDLE   = 8'h01;
    localparam logic [7:0] TPM_ARG_SLEEP  = 8'h02;
    localparam logic [7:0] TPM_MODEL_LEN  = 8'h0c;
    localparam logic [7:0] TPM_WAKE_LEN   = 8'h03;
    localparam logic [7:0] TPM_WAKE_CODE  = 8'h01;
    localparam logic [6:0] TPM_MODEL_END  = 7'h0f;
    localparam logic [6:0] TPM_WAKE_END   = 7'h07;

    // ------------------------------------------------------------
    // Pending reply kinds and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] TPM_RK_NONE    = 2'h0;
    localparam logic [1:0] TPM_RK_MODEL   = 2'h1;
    localparam logic [1:0] TPM_RK_WAKE    = 2'h2;
    localparam logic [7:0] TPM_T_RESET    = 8'h1e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real TPM_SCAN_UNIT_MS      = 0.25;
    localparam real TPM_CLK_PERIOD_NS     = 10.0;
    localparam int  TPM_SCAN_UNIT_CYCLES  = int'(TPM_SCAN_UNIT_MS * 1.0e6 / TPM_CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        TPM_FULL  = 3'b001,
        TPM_IDLE  = 3'b010,
        TPM_SLEEP = 3'b100
    } tpm_mode_type;

    typedef enum logic [3:0] {
        LK_IDLE = 4'b0001,
        LK_ADDR = 4'b0010,
        LK_WR   = 4'b0100,
        LK_RD   = 4'b1000
    } tpm_link_type;

endpackage

// ### tpm_command_ctrl.sv
// Summary of operation
// - After reset the controller runs in full working mode.
// - Model query raises the interrupt; host then reads the reply packet.
// - Model reply carries the product identifier in bytes 11 to 14.
// - An idle request moves full working mode to idle.
// - In idle the interrupt line is released high.
// - A host falling edge on the interrupt line wakes idle to full.
// - In idle a scan is requested every configured interval.
// - Interval is code times 0.25 ms, code zero giving 0.25 ms; code resets to 30.
// - A touch seen by an idle scan returns to full mode alone.
// - In deep sleep the controller answers nothing until woken.
// - Sleep never ends by itself; only a host falling edge wakes it.
// - Every return to full mode pulls the interrupt low with wake notice.
// - The controller answers at link address 0x2a.
// - The interrupt stays low while an unread reply is pending.
module tpm_command_ctrl
    import tpm_pkg::*;
#(
    parameter logic [14:0] SCAN_UNIT_CYC      = 15'(TPM_SCAN_UNIT_CYCLES),
    parameter logic [55:0] MODEL_TEXT         = 56'h41_42_43_44_45_46_47, // Arbitrary value
    parameter logic [31:0] PRODUCT_IDENTIFIER = 32'h51_39_5a_31           // Arbitrary value
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       scl,
    input  wire logic       sda_i,
    output      logic       sda_o,
    output      logic       sda_oe,
    input  wire logic       int_i,
    output      logic       int_o,
    output      logic       int_oe,
    input  wire logic       scan_done,
    input  wire logic       scan_touch,
    output      logic       scan_req,
    output      logic [2:0] power_mode
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic         start_tgl_q;
    logic         stop_tgl_q;
    logic         start_seen_q;
    tpm_link_type phase_q;
    logic [3:0]   bit_cnt_q;
    logic [7:0]   shift_q;
    logic [6:0]   byte_cnt_q;
    logic         ack_q;
    logic         rd_frame_q;
    logic         wr_frame_q;
    logic [2:0]   xs1_q;
    logic [2:0]   xs2_q;
    logic [7:0]   cmd_q [0:9];
    logic         sda_oe_q;
    logic         sda_o_q;
    tpm_mode_type mode_q;
    tpm_mode_type mode_d;
    logic [1:0]   pend_q;
    logic [1:0]   pend_d;
    logic         int_oe_q;
    logic         int_o_q;
    logic         st1_q;
    logic         st2_q;
    logic         st3_q;
    logic         in1_q;
    logic         in2_q;
    logic         in3_q;
    logic [7:0]   interval_q;
    logic [7:0]   interval_d;
    logic [14:0]  unit_cnt_q;
    logic [14:0]  unit_cnt_d;
    logic [7:0]   quarter_q;
    logic [7:0]   quarter_d;
    logic         scan_req_q;

    // ------------------------------------------------------------
    // Start and stop detection on the data line
    // ------------------------------------------------------------
    // Data falling while the clock is high marks a start
    always_ff @(negedge sda_i or negedge reset_n) begin
        if (!reset_n) begin
            start_tgl_q <= 1'b0;
        end else if (scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // Data rising while the clock is high marks a stop
    always_ff @(posedge sda_i or negedge reset_n) begin
        if (!reset_n) begin
            stop_tgl_q <= 1'b0;
        end else if (scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // Link side, clocked by the bus clock
    // ------------------------------------------------------------
    // The start toggle is stable half a bus period before the next rise
    wire       start_now = start_tgl_q ^ start_seen_q;
    wire [7:0] byte_w    = {shift_q[6:0], sda_i};
    wire       ack_bit   = bit_cnt_q == TPM_ACK_BIT;
    wire       byte_end  = bit_cnt_q == TPM_LAST_BIT;
    wire       sleeping  = xs2_q[2];
    wire [1:0] rk_link   = xs2_q[1:0];
    wire       addr_hit  = (byte_w[7:1] == TPM_DEV_ADDR) && !sleeping;
    wire       cmd_we    = byte_end && !ack_bit && !start_now && (phase_q == LK_WR)
                           && (byte_cnt_q < TPM_CMD_BYTES);
    wire       byte_inc  = byte_cnt_q != TPM_BYTE_MAX;

    // Bit, byte and phase tracking
    always_ff @(posedge scl or negedge reset_n) begin
        if (!reset_n) begin
            start_seen_q <= 1'b0;
            phase_q      <= LK_IDLE;
            bit_cnt_q    <= 4'h0;
            shift_q      <= 8'h00;
            byte_cnt_q   <= 7'h00;
            ack_q        <= 1'b0;
            rd_frame_q   <= 1'b0;
            wr_frame_q   <= 1'b0;
            xs1_q        <= 3'h0;
            xs2_q        <= 3'h0;
        end else begin
            start_seen_q <= start_tgl_q;
            xs1_q        <= {mode_q[2], pend_q};
            xs2_q        <= xs1_q;
            if (start_now) begin
                phase_q    <= LK_ADDR;
                bit_cnt_q  <= 4'h1;
                shift_q    <= {7'h00, sda_i};
                byte_cnt_q <= 7'h00;
                ack_q      <= 1'b0;
                rd_frame_q <= 1'b0;
                wr_frame_q <= 1'b0;
            end else if (ack_bit) begin
                bit_cnt_q <= 4'h0;
                ack_q     <= 1'b0;
                case (phase_q)
                    LK_ADDR: begin
                        phase_q <= !ack_q ? LK_IDLE : (rd_frame_q ? LK_RD : LK_WR);
                    end
                    LK_RD: begin
                        // A master not-acknowledge ends the reply
                        if (sda_i) begin
                            phase_q <= LK_IDLE;
                        end else if (byte_inc) begin
                            byte_cnt_q <= byte_cnt_q + 7'h01;
                        end
                    end
                    default: begin
                        phase_q <= phase_q;
                    end
                endcase
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q   <= byte_w;
                if (byte_end) begin
                    case (phase_q)
                        LK_ADDR: begin
                            ack_q      <= addr_hit;
                            rd_frame_q <= addr_hit & byte_w[0];
                            wr_frame_q <= addr_hit & ~byte_w[0];
                        end
                        LK_WR: begin
                            ack_q <= 1'b1;
                            if (byte_inc) begin
                                byte_cnt_q <= byte_cnt_q + 7'h01;
                            end
                        end
                        default: begin
                            ack_q <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Command bytes are data only; the frame flags qualify them
    always_ff @(posedge scl) begin
        if (cmd_we) begin
            cmd_q[byte_cnt_q[3:0]] <= byte_w;
        end
    end

    // ------------------------------------------------------------
    // Reply packets
    // ------------------------------------------------------------
    wire [119:0] model_pkt = {TPM_LEN_LO, TPM_LEN_HI, TPM_RPT_DIAG, TPM_MODEL_LEN,
                              MODEL_TEXT, PRODUCT_IDENTIFIER};
    wire [55:0]  wake_pkt  = {TPM_LEN_LO, TPM_LEN_HI, TPM_RPT_DIAG, TPM_WAKE_LEN,
                              TPM_PWR_B6, TPM_PWR_B7, TPM_WAKE_CODE};
    wire [119:0] model_sh  = model_pkt << {byte_cnt_q[3:0], 3'b000};
    wire [55:0]  wake_sh   = wake_pkt << {byte_cnt_q[2:0], 3'b000};
    wire         model_rng = byte_cnt_q < TPM_MODEL_END;
    wire         wake_rng  = byte_cnt_q < TPM_WAKE_END;
    // Everything past the table reads as zero padding out to 66 bytes
    wire [7:0]   tx_byte   = (rk_link == TPM_RK_MODEL && model_rng) ? model_sh[119:112] :
                             (rk_link == TPM_RK_WAKE && wake_rng) ? wake_sh[55:48] :
                             8'h00;
    wire         tx_bit    = tx_byte[~bit_cnt_q[2:0]];
    wire         drive_d   = (ack_bit & ack_q) | ((phase_q == LK_RD) & ~ack_bit & ~tx_bit);

    // Data changes only while the bus clock is low
    always_ff @(negedge scl or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe_q <= 1'b0;
            sda_o_q  <= 1'b0;
        end else begin
            sda_oe_q <= drive_d;
            sda_o_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Crossings into the system clock
    // ------------------------------------------------------------
    // Stop toggle and the interrupt pin each pass two flops first
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st1_q <= 1'b0;
            st2_q <= 1'b0;
            st3_q <= 1'b0;
            in1_q <= 1'b1;
            in2_q <= 1'b1;
            in3_q <= 1'b1;
        end else begin
            st1_q <= stop_tgl_q;
            st2_q <= st1_q;
            st3_q <= st2_q;
            in1_q <= int_i;
            in2_q <= in1_q;
            in3_q <= in2_q;
        end
    end

    // ------------------------------------------------------------
    // Command decode, valid at the end of a frame
    // ------------------------------------------------------------
    // Link fields are quiet after a stop, so they are read here
    wire frame_end = st2_q ^ st3_q;
    wire hdr_ok    = frame_end && wr_frame_q && (byte_cnt_q >= TPM_CMD_BYTES)
                     && cmd_q[0] == TPM_HDR0 && cmd_q[1] == TPM_HDR1
                     && cmd_q[2] == TPM_LEN_LO && cmd_q[3] == TPM_LEN_HI
                     && cmd_q[4] == TPM_RPT_DIAG;
    wire pwr_ok    = cmd_q[6] == TPM_PWR_B6 && cmd_q[7] == TPM_PWR_B7;
    wire is_query  = hdr_ok && cmd_q[5] == TPM_SUB_QUERY
                     && cmd_q[6] == TPM_QUERY_CHAR;
    wire is_idle   = hdr_ok && pwr_ok && cmd_q[5] == TPM_SUB_IDLE
                     && cmd_q[8] == TPM_ARG_IDLE;
    wire is_sleep  = hdr_ok && pwr_ok && cmd_q[5] == TPM_SUB_SLEEP
                     && cmd_q[8] == TPM_ARG_SLEEP;
    wire rd_done   = frame_end && rd_frame_q;

    // ------------------------------------------------------------
    // Power mode control
    // ------------------------------------------------------------
    wire in_full    = mode_q == TPM_FULL;
    wire in_idle    = mode_q == TPM_IDLE;
    wire in_sleep   = mode_q == TPM_SLEEP;
    // Our own pull is excluded so only the host can make this edge
    wire wake_edge  = in3_q & ~in2_q & ~int_oe_q;
    wire touch_wake = in_idle & scan_done & scan_touch;
    wire wake_now   = ((in_idle | in_sleep) & wake_edge) | touch_wake;

    assign mode_d = wake_now ? TPM_FULL :
                    (in_full & is_idle) ? TPM_IDLE :
                    (in_full & is_sleep) ? TPM_SLEEP :
                    mode_q;

    // A new reply wins over the clear of the old one
    assign pend_d = wake_now ? TPM_RK_WAKE :
                    (in_full & is_query) ? TPM_RK_MODEL :
                    (rd_done | ~in_full | is_idle | is_sleep) ? TPM_RK_NONE :
                    pend_q;

    assign interval_d = (in_full & is_idle) ? cmd_q[9] : interval_q;

    // ------------------------------------------------------------
    // Idle scan timer
    // ------------------------------------------------------------
    // Code zero is treated as one unit rather than a stalled timer
    wire unit_end = unit_cnt_q == (SCAN_UNIT_CYC - 15'h0001);
    wire tick_end = unit_end && ({1'b0, quarter_q} + 9'h001 >= {1'b0, interval_q});

    assign unit_cnt_d = (!in_idle || unit_end) ? 15'h0000 : unit_cnt_q + 15'h0001;
    assign quarter_d  = (!in_idle || tick_end) ? 8'h00 :
                        unit_end ? quarter_q + 8'h01 : quarter_q;

    // Mode, reply and timer state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q     <= TPM_FULL;
            pend_q     <= TPM_RK_NONE;
            int_oe_q   <= 1'b0;
            int_o_q    <= 1'b0;
            interval_q <= TPM_T_RESET;
            unit_cnt_q <= 15'h0000;
            quarter_q  <= 8'h00;
            scan_req_q <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            pend_q     <= pend_d;
            int_oe_q   <= pend_d != TPM_RK_NONE;
            int_o_q    <= 1'b0;
            interval_q <= interval_d;
            unit_cnt_q <= unit_cnt_d;
            quarter_q  <= quarter_d;
            scan_req_q <= in_idle & tick_end & ~wake_now;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_o      = sda_o_q;
    assign sda_oe     = sda_oe_q;
    assign int_o      = int_o_q;
    assign int_oe     = int_oe_q;
    assign scan_req   = scan_req_q;
    assign power_mode = mode_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_full_holds: assert property (@(posedge clock) disable iff (!reset_n)
        in_full && !frame_end |=> mode_q == TPM_FULL)
        else $error("full mode left without a command");
    chk_query_int: assert property (@(posedge clock) disable iff (!reset_n)
        in_full && is_query |=> int_oe && pend_q == TPM_RK_MODEL)
        else $error("model query did not raise the interrupt");
    chk_idle_enter: assert property (@(posedge clock) disable iff (!reset_n)
        in_full && is_idle |=> mode_q == TPM_IDLE && interval_q == $past(cmd_q[9]))
        else $error("idle request not taken");
    chk_idle_release: assert property (@(posedge clock) disable iff (!reset_n)
        in_idle |-> !int_oe)
        else $error("interrupt driven while idle");
    chk_host_wake: assert property (@(posedge clock) disable iff (!reset_n)
        (in_idle || in_sleep) && wake_edge |=> mode_q == TPM_FULL ##1 in_full)
        else $error("host edge did not wake");
    chk_scan_idle: assert property (@(posedge clock) disable iff (!reset_n)
        scan_req |-> $past(in_idle) && !$past(scan_req))
        else $error("scan requested outside idle");
    chk_touch_wake: assert property (@(posedge clock) disable iff (!reset_n)
        in_idle && scan_done && scan_touch |=> in_full && int_oe)
        else $error("touch in idle did not wake");
    chk_sleep_stays: assert property (@(posedge clock) disable iff (!reset_n)
        in_sleep && !wake_edge |=> in_sleep && !int_oe)
        else $error("sleep ended without host edge");
    chk_wake_notice: assert property (@(posedge clock) disable iff (!reset_n)
        !in_full ##1 in_full |-> pend_q == TPM_RK_WAKE && int_oe)
        else $error("wake notice missing");
    // A read stop in the next cycle may end the reply, so only two cycles are owed
    chk_int_level: assert property (@(posedge clock) disable iff (!reset_n)
        pend_q != TPM_RK_NONE && !frame_end && in_full |-> int_oe ##1 int_oe)
        else $error("interrupt released with reply pending");

endmodule

// ### tpm_host_model.sv
module tpm_host_model (
    output logic      scl,
    output logic      sda_low,
    output logic      int_low,
    input  wire logic sda,
    input  wire logic int_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Bus primitives, 160 ns bit time
    // ----------------------------------------
    // Clock rests high between frames, so the link stands still outside them
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        int_low = 1'b0;
    end

    // Data moves 20 ns after the low edge to keep some hold time
    task automatic bit_x(input logic b, output logic got);
        #20 sda_low = ~b;
        #60 scl = 1'b1;
        #80 got = sda;
        scl = 1'b0;
    endtask

    // Eight bits MSB first, then the ninth bit; ack is the far end pulling low
    task automatic byte_x(input logic [7:0] v, input logic last, output logic [7:0] got, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], g);
            got[i] = g;
        end
        bit_x(last, g);
        ack = ~g;
    endtask

    task automatic start_c();
        sda_low = 1'b0;
        scl = 1'b1;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
    endtask

    task automatic stop_c();
        #20 sda_low = 1'b1;
        #60 scl = 1'b1;
        #80 sda_low = 1'b0;
        #160;
    endtask

    // ----------------------------------------
    // Frames
    // ----------------------------------------
    // Ten command bytes, then padding up to 68 bytes; a refused address ends the frame
    task automatic write_frame(input logic [6:0] addr, input logic [79:0] pkt, input logic [7:0] pad, output logic ok);
        logic [7:0] g;
        logic       a;
        start_c();
        byte_x({addr, 1'b0}, 1'b1, g, ok);
        for (int i = 0; i < 68 && ok; i++) begin
            byte_x(i < 10 ? pkt[79 - 8 * i -: 8] : pad, 1'b1, g, a);
            ok = ok & a; // Every data byte must be acknowledged as well
        end
        stop_c();
    endtask

    // 66 bytes once the address is acknowledged, nak on the last one; first 16 kept
    task automatic read_frame(output logic ok, output logic [7:0] rd [0:15]);
        logic [7:0] g;
        logic       a;
        start_c();
        byte_x({7'h2a, 1'b1}, 1'b1, g, ok);
        for (int i = 0; i < 66 && ok; i++) begin
            byte_x(8'hff, i == 65, g, a);
            if (i < 16) rd[i] = g;
        end
        stop_c();
    endtask

    // Falling edge on the interrupt wire, released after 400 ns
    task automatic wake_edge();
        int_low = 1'b1;
        #400 int_low = 1'b0;
    endtask
endmodule

// ### test_touch_power_mode_commands.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_touch_power_mode_commands
    import tpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Constants and wires
    // ----------------------------------------
    localparam logic [55:0]  MODEL_V   = 56'h54_4f_55_43_48_30_31; // Arbitrary value
    localparam logic [31:0]  PID_V     = 32'h37_4b_39_32;          // Arbitrary value
    localparam logic [119:0] MODEL_PKT = {32'h42_00_03_0c, MODEL_V, PID_V};
    localparam logic [55:0]  WAKE_PKT  = 56'h42_00_03_03_36_3f_01;
    localparam logic [39:0]  HDR       = 40'h67_00_42_00_03;
    localparam logic [14:0]  UNIT      = 15'h0004; // Short scan unit keeps the run small
    localparam int           LIMIT     = 95000;

    logic       clock, reset_n, scan_done, scan_touch, sda_oe, int_oe, scan_req, sda_o, int_o;
    logic       host_scl, host_sda_low, host_int_low;
    logic [2:0] power_mode;
    // Pull-ups on both wires; a high drive value would lose every pull-down
    wire logic  sda_w = ~((sda_oe & ~sda_o) | host_sda_low);
    wire logic  int_w = ~((int_oe & ~int_o) | host_int_low);
    int         err_total = 0;
    int         check_count = 0;
    int         cycles = 0;
    int         seed_v;

    tpm_command_ctrl #(
        .SCAN_UNIT_CYC      (UNIT),
        .MODEL_TEXT         (MODEL_V),
        .PRODUCT_IDENTIFIER (PID_V)
    ) u_tpm_command_ctrl (
        .clock      (clock),
        .reset_n    (reset_n),
        .scl        (host_scl),
        .sda_i      (sda_w),
        .sda_o      (sda_o),
        .sda_oe     (sda_oe),
        .int_i      (int_w),
        .int_o      (int_o),
        .int_oe     (int_oe),
        .scan_done  (scan_done),
        .scan_touch (scan_touch),
        .scan_req   (scan_req),
        .power_mode (power_mode)
    );

    tpm_host_model u_tpm_host_model (
        .scl      (host_scl),
        .sda_low  (host_sda_low),
        .int_low  (host_int_low),
        .sda      (sda_w),
        .int_wire (int_w)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] exp_byte(input logic model, input int i);
        if (model) return (i < 15) ? MODEL_PKT[119 - 8 * i -: 8] : 8'h00;
        return (i < 7) ? WAKE_PKT[55 - 8 * i -: 8] : 8'h00;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Sample just after the edge so register outputs have landed
    task automatic tick(inout int n);
        @(posedge clock);
        #1;
        n++;
    endtask

    task automatic wait_state(input logic [2:0] m, input logic i);
        int n;
        n = 0;
        while ((power_mode !== m || int_oe !== i) && n < 3000) tick(n);
        `CHK({power_mode, int_oe}, {m, i})
    endtask

    task automatic check_reply(input logic model);
        logic       ok;
        logic [7:0] rd [0:15];
        u_tpm_host_model.read_frame(ok, rd);
        `CHK(ok, 1'b1)
        for (int i = 0; i < 16; i++) `CHK(rd[i], exp_byte(model, i))
        wait_state(TPM_FULL, 1'b0);
    endtask

    // Enter idle and time the gap between two scan requests
    task automatic idle_enter(input logic [7:0] code);
        logic ok;
        int   gap, n;
        u_tpm_host_model.write_frame(7'h2a, {HDR, TPM_SUB_IDLE, TPM_PWR_B6, TPM_PWR_B7, TPM_ARG_IDLE, code},
                                     8'h00, ok);
        `CHK(ok, 1'b1)
        wait_state(TPM_IDLE, 1'b0);
        n = 0;
        while (scan_req !== 1'b1 && n < 2000) tick(n);
        gap = 0;
        tick(gap);
        while (scan_req !== 1'b1 && gap < 2000) tick(gap);
        `CHK(gap, int'(code) * int'(UNIT))
    endtask

    task automatic scan_pulse(input logic t);
        @(posedge clock);
        scan_done <= 1'b1;
        scan_touch <= t;
        @(posedge clock);
        scan_done <= 1'b0;
    endtask

    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // A hang counts as a mismatch and still reaches the report
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            results();
        end
    end

    initial begin
        logic       ok;
        logic [7:0] pad;
        int         n;
        reset_n = 1'b0;
        scan_done = 1'b0;
        scan_touch = 1'b0;
        seed_v = $urandom(12128);
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK({power_mode, int_oe, scan_req}, {TPM_FULL, 2'b00})
        u_tpm_host_model.write_frame(7'h2b, {HDR, 40'h0}, 8'h00, ok);
        `CHK(ok, 1'b0)
        $display("test reset_and_address finished");
        pad = 8'($urandom_range(255, 1));
        u_tpm_host_model.write_frame(7'h2a, {HDR, TPM_SUB_QUERY, TPM_QUERY_CHAR, 24'h0}, pad, ok);
        `CHK(ok, 1'b1)
        wait_state(TPM_FULL, 1'b1);
        check_reply(1'b1);
        $display("test model_query finished");
        idle_enter(8'($urandom_range(4, 1)));
        scan_pulse(1'b0);
        n = 0;
        repeat (20) tick(n);
        `CHK(power_mode, TPM_IDLE)
        scan_pulse(1'b1);
        wait_state(TPM_FULL, 1'b1);
        check_reply(1'b0);
        $display("test idle_touch finished");
        idle_enter(TPM_T_RESET);
        u_tpm_host_model.wake_edge();
        wait_state(TPM_FULL, 1'b1);
        check_reply(1'b0);
        $display("test idle_host_wake finished");
        u_tpm_host_model.write_frame(7'h2a, {HDR, TPM_SUB_SLEEP, TPM_PWR_B6, TPM_PWR_B7, TPM_ARG_SLEEP, 8'h00},
                                     8'h00, ok);
        `CHK(ok, 1'b1)
        wait_state(TPM_SLEEP, 1'b0);
        u_tpm_host_model.write_frame(7'h2a, {HDR, 40'h0}, 8'h00, ok);
        `CHK(ok, 1'b0)
        scan_pulse(1'b1);
        n = 0;
        repeat (400) begin
            @(posedge clock);
            #1;
            if (scan_req === 1'b1 || power_mode !== TPM_SLEEP) n++;
        end
        `CHK(n, 0)
        u_tpm_host_model.wake_edge();
        wait_state(TPM_FULL, 1'b1);
        check_reply(1'b0);
        $display("test sleep finished");
        results();
    end
endmodule
